/* File: pstim_top.sv */
// rail grouping, fault action selection, pin trigger gating and irq gating
// assumes: host register port is synchronous to core_clk_i; pins and events are asynchronous
`timescale 1ns/1ps
module pstim_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [pstim_pkg::NUM_PINS-1:0] pin_level_i,
  input wire logic [pstim_pkg::NUM_IRQ_EVENTS-1:0] irq_event_i,
  input wire logic [2:0] fault_class_i,
  output logic config_ready_o,
  output logic [pstim_pkg::NUM_PINS-1:0] pin_trigger_o,
  output logic [pstim_pkg::NUM_RAILS-1:0] micro_group_o,
  output logic [pstim_pkg::NUM_RAILS-1:0] soc_group_o,
  output logic [1:0] micro_group_fault_action_o,
  output logic [1:0] soc_group_fault_action_o,
  output logic [1:0] ungrouped_fault_action_o,
  output logic [1:0] severe_fault_action_o,
  output logic [1:0] medium_fault_action_o,
  output logic fault_action_valid_o,
  output logic [1:0] fault_action_o,
  output logic interrupt_out_n_o,
  output logic interrupt_out_n_oe_o
);
  // ==========================================================
  // reset release and pin, event and fault class synchronisers
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];
  logic [pstim_pkg::NUM_PINS-1:0] pin_s;
  logic [pstim_pkg::NUM_IRQ_EVENTS-1:0] evt_s;
  logic [2:0] fault_s;
  pstim_sync #(.WIDTH(pstim_pkg::NUM_PINS + pstim_pkg::NUM_IRQ_EVENTS + 3)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .async_i({fault_class_i, irq_event_i, pin_level_i}),
    .sync_o({fault_s, evt_s, pin_s})
  );
  // ==========================================================
  // state
  typedef struct packed {
    pstim_pkg::pstim_phase_t phase;
    logic [4:0] load_idx;
    logic [pstim_pkg::NUM_REGS-1:0][7:0] regs;
    logic [pstim_pkg::NUM_PINS-1:0] trig;
    logic [1:0] action;
    logic action_valid;
    logic irq_active;
  } pstim_state_t;
  pstim_state_t state, next_state;
  // field helpers
  function automatic logic [1:0] grp_field(input logic [7:0] r, input int slot);
    grp_field = r[slot*2 +: 2];
  endfunction
  function automatic logic [1:0] gate_pair(input logic [7:0] r, input int pin);
    gate_pair = r[pin*2 +: 2];
  endfunction
  logic [pstim_pkg::NUM_RAILS-1:0][1:0] grp;
  logic [pstim_pkg::NUM_PINS-1:0][1:0] gates;
  logic [pstim_pkg::NUM_IRQ_EVENTS-1:0] irq_gate;
  logic [4:0][1:0] act;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      grp[i] = grp_field(state.regs[pstim_pkg::IDX_RAIL_A], i);
      grp[i+4] = grp_field(state.regs[pstim_pkg::IDX_RAIL_B], i);
      gates[i] = gate_pair(state.regs[pstim_pkg::IDX_PIN_A], i);
      gates[i+4] = gate_pair(state.regs[pstim_pkg::IDX_PIN_B], i);
      act[i] = grp_field(state.regs[pstim_pkg::IDX_ACT_A], i);
    end
    grp[8] = grp_field(state.regs[pstim_pkg::IDX_RAIL_C], 0);
    grp[9] = grp_field(state.regs[pstim_pkg::IDX_RAIL_C], 1);
    for (int i = 0; i < 3; i++) begin
      gates[i+8] = gate_pair(state.regs[pstim_pkg::IDX_PIN_C], i);
    end
    act[4] = grp_field(state.regs[pstim_pkg::IDX_ACT_B], 0);
    irq_gate = {state.regs[pstim_pkg::IDX_MISC][2:0], state.regs[pstim_pkg::IDX_UPPER][5:0],
                state.regs[pstim_pkg::IDX_RISE], state.regs[pstim_pkg::IDX_FALL],
                state.regs[pstim_pkg::IDX_START][3:0], state.regs[pstim_pkg::IDX_SUP][1:0],
                state.regs[pstim_pkg::IDX_LIN34][5:0], state.regs[pstim_pkg::IDX_LIN12][5:0],
                state.regs[pstim_pkg::IDX_SW5][2:0], state.regs[pstim_pkg::IDX_SW34][5:0],
                state.regs[pstim_pkg::IDX_SW12][5:0]};
  end
  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.action_valid = 1'b0;
    case (state.phase)
      pstim_pkg::PSTIM_LOADING: begin
        next_state.regs[state.load_idx] =
          pstim_pkg::DEFAULTS[state.load_idx*8 +: 8];
        if (state.load_idx == 5'(pstim_pkg::NUM_REGS - 1)) begin
          next_state.phase = pstim_pkg::PSTIM_RUN;
        end else begin
          next_state.load_idx = state.load_idx + 5'h01;
        end
      end
      pstim_pkg::PSTIM_RUN: begin
        if (reg_wr_i && reg_addr_i < 5'(pstim_pkg::NUM_REGS)) begin
          next_state.regs[reg_addr_i] = reg_wdata_i;
        end
        for (int i = 0; i < pstim_pkg::NUM_PINS; i++) begin
          if (gates[i][0]) begin
            next_state.trig[i] = gates[i][1];
          end else begin
            next_state.trig[i] = pin_s[i];
          end
        end
        next_state.irq_active = |(evt_s & ~irq_gate);
        if (fault_s <= 3'h4) begin
          next_state.action = act[fault_s];
          next_state.action_valid = 1'b1;
        end
      end
      default: begin
        next_state.phase = pstim_pkg::PSTIM_LOADING;
      end
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  // ==========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < pstim_pkg::NUM_RAILS; i++) begin
      micro_group_o[i] = (grp[i] == pstim_pkg::GRP_MICRO);
      soc_group_o[i] = (grp[i] == pstim_pkg::GRP_SOC);
    end
  end
  assign reg_rdata_o = (reg_addr_i < 5'(pstim_pkg::NUM_REGS)) ? state.regs[reg_addr_i] : 8'h00;
  assign config_ready_o = (state.phase == pstim_pkg::PSTIM_RUN);
  assign pin_trigger_o = state.trig;
  assign micro_group_fault_action_o = act[0];
  assign soc_group_fault_action_o = act[1];
  assign ungrouped_fault_action_o = act[2];
  assign severe_fault_action_o = act[3];
  assign medium_fault_action_o = act[4];
  assign fault_action_o = state.action;
  assign fault_action_valid_o = state.action_valid;
  assign interrupt_out_n_o = 1'b0;
  assign interrupt_out_n_oe_o = state.irq_active;
endmodule // pstim_top

/* File: pstim_pkg.sv */
// package: register indices, field layouts and loaded defaults for trigger/irq config
// assumes: byte-wide registers reached through the host parallel register port
package pstim_pkg;
  // register indices
  localparam logic [4:0] IDX_RAIL_A = 5'h00;
  localparam logic [4:0] IDX_RAIL_B = 5'h01;
  localparam logic [4:0] IDX_RAIL_C = 5'h02;
  localparam logic [4:0] IDX_ACT_A = 5'h03;
  localparam logic [4:0] IDX_ACT_B = 5'h04;
  localparam logic [4:0] IDX_PIN_A = 5'h05;
  localparam logic [4:0] IDX_PIN_B = 5'h06;
  localparam logic [4:0] IDX_PIN_C = 5'h07;
  localparam logic [4:0] IDX_SW12 = 5'h08;
  localparam logic [4:0] IDX_SW34 = 5'h09;
  localparam logic [4:0] IDX_SW5 = 5'h0A;
  localparam logic [4:0] IDX_LIN12 = 5'h0B;
  localparam logic [4:0] IDX_LIN34 = 5'h0C;
  localparam logic [4:0] IDX_SUP = 5'h0D;
  localparam logic [4:0] IDX_FALL = 5'h0E;
  localparam logic [4:0] IDX_RISE = 5'h0F;
  localparam logic [4:0] IDX_UPPER = 5'h10;
  localparam logic [4:0] IDX_START = 5'h11;
  localparam logic [4:0] IDX_MISC = 5'h12;
  localparam int NUM_REGS = 19;
  // group choice and fault action encodings
  localparam logic [1:0] GRP_MICRO = 2'h1;
  localparam logic [1:0] GRP_SOC = 2'h2;
  localparam logic [1:0] ACT_IMMEDIATE = 2'h0;
  localparam logic [1:0] ACT_ORDERLY = 2'h1;
  localparam logic [1:0] ACT_MICRO_ERR = 2'h2;
  localparam int NUM_RAILS = 10;
  localparam int NUM_PINS = 11;
  localparam int NUM_IRQ_EVENTS = 58;
  // loaded defaults
  localparam logic [7:0] DEF_RAIL_A = 8'hA5;
  localparam logic [7:0] DEF_RAIL_B = 8'h95;
  localparam logic [7:0] DEF_RAIL_C = 8'h05;
  localparam logic [7:0] DEF_ACT_A = 8'h1A;
  localparam logic [7:0] DEF_ACT_B = 8'h01;
  localparam logic [7:0] DEF_PIN_A = 8'h55;
  localparam logic [7:0] DEF_PIN_B = 8'h55;
  localparam logic [7:0] DEF_PIN_C = 8'h1D;
  localparam logic [7:0] DEF_SW12 = 8'h00;
  localparam logic [7:0] DEF_SW34 = 8'h00;
  localparam logic [7:0] DEF_SW5 = 8'h00;
  localparam logic [7:0] DEF_LIN12 = 8'h00;
  localparam logic [7:0] DEF_LIN34 = 8'h00;
  localparam logic [7:0] DEF_SUP = 8'h00;
  localparam logic [7:0] DEF_FALL = 8'hFF;
  localparam logic [7:0] DEF_RISE = 8'hFF;
  localparam logic [7:0] DEF_UPPER = 8'h3B;
  localparam logic [7:0] DEF_START = 8'h05;
  localparam logic [7:0] DEF_MISC = 8'h04;
  localparam logic [NUM_REGS*8-1:0] DEFAULTS = {
    DEF_MISC, DEF_START, DEF_UPPER, DEF_RISE, DEF_FALL, DEF_SUP, DEF_LIN34, DEF_LIN12,
    DEF_SW5, DEF_SW34, DEF_SW12, DEF_PIN_C, DEF_PIN_B, DEF_PIN_A, DEF_ACT_B, DEF_ACT_A,
    DEF_RAIL_C, DEF_RAIL_B, DEF_RAIL_A};
  // load sequencer
  typedef enum logic [1:0] {PSTIM_LOADING, PSTIM_RUN} pstim_phase_t;
endpackage

/* File: pstim_sync.sv */
// two-flop synchroniser for a bus of pin, event and fault class inputs
// assumes: inputs asynchronous to core_clk_i
`timescale 1ns/1ps
module pstim_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } pstim_sync_state_t;
  pstim_sync_state_t state, next_state;
  always_comb begin
    next_state.first = async_i;
    next_state.second = state.first;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign sync_o = state.second;
endmodule // pstim_sync

/* File: pstim_monitor.sv */
// checker: port relations of register, group, action and irq config
// assumes: bound to pstim_top, one clock domain
`timescale 1ns/1ps
module pstim_monitor (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [pstim_pkg::NUM_IRQ_EVENTS-1:0] irq_event_i,
  input wire logic [2:0] fault_class_i,
  input wire logic config_ready_o,
  input wire logic [9:0] micro_group_o,
  input wire logic [9:0] soc_group_o,
  input wire logic [1:0] severe_fault_action_o,
  input wire logic fault_action_valid_o,
  input wire logic [1:0] fault_action_o,
  input wire logic interrupt_out_n_o,
  input wire logic interrupt_out_n_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ====
  // sequences
  sequence class_live;
    config_ready_o && fault_class_i < 3'h5;
  endsequence
  sequence severe_held;
    (config_ready_o && fault_class_i == 3'h3 && $stable(severe_fault_action_o)) [*4];
  endsequence
  // ====
  // assertions
  a_pin_data_low: assert property (interrupt_out_n_o == 1'b0)
    else $error("irq data not low");
  a_quiet_events: assert property ((irq_event_i == '0) [*4] |-> !interrupt_out_n_oe_o)
    else $error("irq without event");
  a_ready_holds: assert property (config_ready_o |=> config_ready_o)
    else $error("ready dropped");
  a_loading_quiet: assert property (!config_ready_o |->
    !interrupt_out_n_oe_o && !fault_action_valid_o) else $error("output before load");
  a_group_unique: assert property ((micro_group_o & soc_group_o) == 10'h000)
    else $error("rail in both groups");
  a_write_lands: assert property (config_ready_o && reg_wr_i && reg_addr_i < 5'h13 ##1
    $stable(reg_addr_i) |-> reg_rdata_o == $past(reg_wdata_i)) else $error("write lost");
  a_unmapped_zero: assert property (reg_addr_i > 5'h12 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_class_valid: assert property (class_live [*4] |-> fault_action_valid_o)
    else $error("valid missing");
  a_class_none: assert property ((fault_class_i > 3'h4) [*4] |-> !fault_action_valid_o)
    else $error("valid without class");
  a_severe_action: assert property (severe_held |->
    fault_action_o == severe_fault_action_o) else $error("severe action wrong");
endmodule // pstim_monitor

bind pstim_top pstim_monitor u_mon (.core_clk_i, .reset_n_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .irq_event_i, .fault_class_i, .config_ready_o, .micro_group_o,
  .soc_group_o, .severe_fault_action_o, .fault_action_valid_o, .fault_action_o,
  .interrupt_out_n_o, .interrupt_out_n_oe_o);

/* File: pstim_host.sv */
// host model: byte register writes and reads
// assumes: register port synchronous to core_clk_i
`timescale 1ns/1ps
module pstim_host (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [4:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 8'h00;
  end
  // ====
  // bus tasks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    @(posedge core_clk_i);
    d = reg_rdata_i;
  endtask
endmodule // pstim_host

/* File: tb.sv */
// testbench: register model against group, action, pin and irq outputs
// assumes: pstim_top, pstim_host and bound checker
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, wr, ready, valid, oe, odat;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [10:0] pins = 11'h000, trig;
  logic [57:0] ev = 58'h0;
  logic [2:0] cls = 3'h7;
  logic [9:0] mg, sg;
  logic [1:0] act, a0, a1, a2, a3, a4;
  logic [7:0] exp_r [19];
  int unsigned rn;
  int fails = 0, samples_checked = 0, cyc = 0;
  always #4 clk = ~clk;
  pstim_top dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pin_level_i(pins), .irq_event_i(ev),
    .fault_class_i(cls), .config_ready_o(ready), .pin_trigger_o(trig), .micro_group_o(mg),
    .soc_group_o(sg), .micro_group_fault_action_o(a0), .soc_group_fault_action_o(a1),
    .ungrouped_fault_action_o(a2), .severe_fault_action_o(a3), .medium_fault_action_o(a4),
    .fault_action_valid_o(valid), .fault_action_o(act), .interrupt_out_n_o(odat),
    .interrupt_out_n_oe_o(oe));
  pstim_host host (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata));
  task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [1:0] fld(int r, int i);
    logic [23:0] c;
    c = {exp_r[r+2], exp_r[r+1], exp_r[r]};
    return c[2*i +: 2];
  endfunction
  task automatic check_all;
    logic [1:0] f;
    for (int i = 0; i < 20; i++) begin
      host.rd((i < 19) ? 5'(i) : 5'h1F, rv);
      cmp("reg", (i < 19) ? exp_r[i] : 8'h00, rv);
    end
    for (int i = 0; i < 10; i++) begin
      f = fld(0, i);
      cmp("group", {f == 2'h1, f == 2'h2}, {mg[i], sg[i]});
    end
    cmp("acts", {fld(3, 4), fld(3, 3), fld(3, 2), fld(3, 1), fld(3, 0)},
      {a4, a3, a2, a1, a0});
    for (int i = 0; i < 11; i++) begin
      f = fld(5, i);
      cmp("trig", f[0] ? f[1] : pins[i], trig[i]);
    end
    cmp("valid", cls < 3'h5, valid);
    if (cls < 3'h5) cmp("act", fld(3, cls), act);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'h797ae8c6));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 19; i++) exp_r[i] = pstim_pkg::DEFAULTS[8*i +: 8];
    for (int i = 0; i < 60 && ready !== 1'b1; i++) @(posedge clk);
    #1 cmp("ready", 1, ready);
    cmp("dflt", {10'h373, 10'h08C, 11'h200, 10'h11A},
      {mg, sg, trig, a4, a3, a2, a1, a0});
    check_all;
    repeat (40) begin
      rn = $urandom;
      host.wr(5'(rn % 21), rn[15:8]);
      if (rn % 21 < 19) exp_r[rn % 21] = rn[15:8];
      pins <= 11'($urandom);
      cls <= 3'($urandom);
      repeat (4) @(posedge clk);
      check_all;
    end
    for (int g = 0; g < 2; g++) begin
      for (int r = 8; r < 19; r++) host.wr(5'(r), g ? 8'hFF : 8'h00);
      ev <= 58'({$urandom, $urandom}) | 58'h1;
      repeat (4) @(posedge clk);
      #1 cmp("irq", g == 0, oe);
      cmp("irq_data", 0, odat);
      ev <= 58'h0;
      repeat (4) @(posedge clk);
      #1 cmp("irq", 0, oe);
    end
    host.wr(pstim_pkg::IDX_SW12, 8'hFE);
    ev <= 58'h1;
    repeat (4) @(posedge clk);
    #1 cmp("irq", 1, oe);
    ev <= 58'h2;
    repeat (4) @(posedge clk);
    #1 cmp("irq", 0, oe);
    test_done;
  end
endmodule // tb
